// file: common/sis_cfg.svh
// register offsets, field positions, reset values and timing counts for the stack and interrupt sequencer
`ifndef SIS_CFG_SVH
`define SIS_CFG_SVH
`define SIS_IO_IRQ_EN 6'h29
`define SIS_IO_IRQ_FLAG 6'h2a
`define SIS_IO_IRQ_CTRL 6'h2b
`define SIS_IO_SP_LOW 6'h2d
`define SIS_IO_SP_HIGH 6'h2e
`define SIS_IO_STATUS 6'h2f
`define SIS_GIE_BIT 7
`define SIS_VSEL_BIT 1
`define SIS_SP_HIGH_BITS 2
`define SIS_SP_RESET 10'h000
`define SIS_STATUS_RESET 8'h00
`define SIS_CTRL_RESET 8'h00
`define SIS_IRQ_RESET 8'h00
`define SIS_ENTRY_CYCLES 4'h4
`define SIS_WAKE_EXTRA 4'h4
`define SIS_RETURN_CYCLES 4'h4
`define SIS_VEC_STRIDE 16'h0002
`define SIS_PTR_BASE_REG 5'h1a
`endif

// file: common/sis_pkg.sv
// shared types for the stack and interrupt sequencer
package sis_pkg;
	typedef enum logic [1:0] {SIS_IDLE, SIS_ENTRY, SIS_RETURN} sis_state_t;
	typedef enum logic [1:0] {SIS_PTR_PLAIN, SIS_PTR_DISP, SIS_PTR_POSTINC, SIS_PTR_PREDEC} sis_ptr_mode_t;
	// one-cycle strobes from the instruction sequencer
	typedef struct packed {
		logic push_byte;
		logic pop_byte;
		logic call;
		logic ret;
		logic return_from_irq;
		logic sei;
		logic cli;
		logic instr_done;
	} sis_cmd_t;
	typedef struct packed {
		logic we;
		logic re;
		logic [5:0] addr;
		logic [7:0] wdata;
	} sis_io_req_t;
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic we;
		logic re;
	} sis_mem_req_t;
endpackage

// file: verilog/sis_ptr_unit.sv
// indirect pointer pair address and write-back calculation
`timescale 1ns/1ns
`default_nettype none
module sis_ptr_unit import sis_pkg::*; (
	input wire logic [7:0] ptr_low,
	input wire logic [7:0] ptr_high,
	input wire sis_ptr_mode_t mode,
	input wire logic [5:0] disp,
	output logic [15:0] eff_addr,
	output logic [7:0] upd_low,
	output logic [7:0] upd_high,
	output logic upd_we
);
	logic [15:0] ptr;
	logic [15:0] nxt;
	assign ptr = {ptr_high, ptr_low};
	// both bytes read, adjusted and handed back in the same cycle
	always_comb begin
		nxt = ptr;
		eff_addr = ptr;
		upd_we = 1'b0;
		unique case (mode)
			SIS_PTR_PLAIN: begin
				eff_addr = ptr;
			end
			SIS_PTR_DISP: begin
				eff_addr = ptr + {10'h000, disp};
			end
			SIS_PTR_POSTINC: begin
				nxt = ptr + 16'h0001;
				upd_we = 1'b1;
			end
			SIS_PTR_PREDEC: begin
				nxt = ptr - 16'h0001;
				eff_addr = nxt;
				upd_we = 1'b1;
			end
		endcase
	end
	assign upd_low = nxt[7:0];
	assign upd_high = nxt[15:8];
endmodule
`default_nettype wire

// file: verilog/sis_prio_enc.sv
// fixed priority encoder, lowest index wins
`timescale 1ns/1ns
`default_nettype none
module sis_prio_enc #(
	parameter int N = 8,
	parameter int W = 3
) (
	input wire logic [N-1:0] req,
	output logic any,
	output logic [W-1:0] idx
);
	logic [N:0] seen;
	logic [N-1:0] onehot;
	assign seen[0] = 1'b0;
	// lower index means lower vector address, so it ranks higher
	genvar i;
	for (i = 0; i < N; i++) begin : g_rank
		assign seen[i+1] = seen[i] | req[i];
		assign onehot[i] = req[i] & ~seen[i];
	end
	assign any = seen[N];
	always_comb begin
		idx = '0;
		for (int k = 0; k < N; k++) begin
			if (onehot[k]) begin
				idx = W'(k);
			end
		end
	end
endmodule
`default_nettype wire

// file: verilog/sis_sequencer.sv
// stack pointer, pointer pairs and interrupt entry/return sequencing
`timescale 1ns/1ns
`default_nettype none
`include "sis_cfg.svh"
module sis_sequencer import sis_pkg::*; #(
	parameter int N_SRC = 8,
	parameter int IDX_W = 3,
	parameter logic [N_SRC-1:0] LEVEL_MASK = 8'h00,
	parameter logic [15:0] BOOT_START = 16'h0c00
) (
	input wire logic clock,
	input wire logic srst,
	input wire sis_cmd_t cmd,
	input wire sis_io_req_t io_req,
	output logic [7:0] io_rdata,
	input wire logic [15:0] pc_now,
	input wire logic pc_in_boot,
	input wire logic sleep_ready,
	input wire logic [N_SRC-1:0] src_event,
	input wire logic [N_SRC-1:0] src_level,
	input wire logic boot_reset_fuse,
	input wire logic app_lock_bit,
	input wire logic boot_lock_bit,
	output sis_mem_req_t mem_req,
	input wire logic [7:0] mem_rdata,
	output logic pc_load,
	output logic [15:0] pc_value,
	output logic [15:0] reset_vector,
	output logic [9:0] stack_top_pointer,
	output logic global_enable,
	output logic busy,
	output logic wake_req,
	input wire logic [7:0] ptr_low,
	input wire logic [7:0] ptr_high,
	input wire logic [1:0] ptr_sel,
	input wire sis_ptr_mode_t ptr_mode,
	input wire logic [5:0] ptr_disp,
	output logic [15:0] ptr_addr,
	output logic [4:0] ptr_wb_index,
	output logic [7:0] ptr_wb_low,
	output logic [7:0] ptr_wb_high,
	output logic ptr_wb_we
);
	// everything runs on the one undivided core clock
	sis_state_t state_q;
	logic [3:0] cnt_q;
	logic [3:0] entry_len_q;
	logic [9:0] sp_q;
	logic [9:0] sp_d;
	logic [7:0] status_q;
	logic [7:0] ctrl_q;
	logic [N_SRC-1:0] irq_en_q;
	logic [N_SRC-1:0] flag_q;
	logic [N_SRC-1:0] req_vec;
	logic [IDX_W-1:0] win_idx;
	logic [IDX_W-1:0] src_q;
	logic [7:0] pc_high_q;
	logic [7:0] pc_low_q;
	logic shadow_q;
	logic any_req;
	logic gie_eff;
	logic blocked;
	logic take;
	logic ret_go;
	logic entry_last;
	logic return_last;
	logic [15:0] vec_base;
	logic wr_spl;
	logic wr_sph;
	logic wr_status;

	assign wr_spl = io_req.we && io_req.addr == `SIS_IO_SP_LOW;
	assign wr_sph = io_req.we && io_req.addr == `SIS_IO_SP_HIGH;
	assign wr_status = io_req.we && io_req.addr == `SIS_IO_STATUS;

	// pointer pairs live in the register file; only the address math is here
	sis_ptr_unit u_ptr (
		.ptr_low(ptr_low),
		.ptr_high(ptr_high),
		.mode(ptr_mode),
		.disp(ptr_disp),
		.eff_addr(ptr_addr),
		.upd_low(ptr_wb_low),
		.upd_high(ptr_wb_high),
		.upd_we(ptr_wb_we)
	);
	assign ptr_wb_index = `SIS_PTR_BASE_REG + {2'b00, ptr_sel, 1'b0};

	// level sources feed straight through, so a vanished condition never requests
	// lock bits shut out vectors that would jump across the protected boundary
	assign blocked = (app_lock_bit && !pc_in_boot && ctrl_q[`SIS_VSEL_BIT])
		|| (boot_lock_bit && pc_in_boot && !ctrl_q[`SIS_VSEL_BIT]);
	assign req_vec = (flag_q | (src_level & LEVEL_MASK)) & irq_en_q & {N_SRC{!blocked}};

	sis_prio_enc #(
		.N(N_SRC),
		.W(IDX_W)
	) u_prio (
		.req(req_vec),
		.any(any_req),
		.idx(win_idx)
	);

	// clear-global kills acceptance in its own cycle
	assign gie_eff = status_q[`SIS_GIE_BIT] && !cmd.cli;
	// only at an instruction boundary or while sleep_ready is high, so multi-cycle work has finished
	// a boundary closes the one held instruction; the hold only stops a wake before it
	assign take = state_q == SIS_IDLE && any_req && gie_eff
		&& ((cmd.instr_done && !cmd.sei && !cmd.return_from_irq) || (sleep_ready && !shadow_q));
	assign ret_go = state_q == SIS_IDLE && cmd.return_from_irq && cmd.instr_done;
	assign entry_last = state_q == SIS_ENTRY && cnt_q == entry_len_q - 4'h1;
	assign return_last = state_q == SIS_RETURN && cnt_q == `SIS_RETURN_CYCLES - 4'h1;
	assign wake_req = sleep_ready && any_req && status_q[`SIS_GIE_BIT];
	assign busy = state_q != SIS_IDLE;

	// vector table base follows the select bit; reset vector follows the fuse
	assign vec_base = ctrl_q[`SIS_VSEL_BIT] ? BOOT_START : 16'h0000;
	assign reset_vector = boot_reset_fuse ? BOOT_START : 16'h0000;

	// sequencing state; the wake penalty is fixed at the moment of acceptance
	always_ff @(posedge clock) begin
		if (srst) begin
			state_q <= SIS_IDLE;
			cnt_q <= 4'h0;
			entry_len_q <= `SIS_ENTRY_CYCLES;
			src_q <= '0;
		end else begin
			unique case (state_q)
				SIS_IDLE: begin
					cnt_q <= 4'h0;
					if (take) begin
						state_q <= SIS_ENTRY;
						src_q <= win_idx;
						entry_len_q <= sleep_ready ? `SIS_ENTRY_CYCLES + `SIS_WAKE_EXTRA : `SIS_ENTRY_CYCLES;
					end else if (ret_go) begin
						state_q <= SIS_RETURN;
					end
				end
				SIS_ENTRY: begin
					cnt_q <= cnt_q + 4'h1;
					if (entry_last) begin
						state_q <= SIS_IDLE;
					end
				end
				SIS_RETURN: begin
					cnt_q <= cnt_q + 4'h1;
					if (return_last) begin
						state_q <= SIS_IDLE;
					end
				end
			endcase
		end
	end

	// stack memory traffic: two pushes on entry, two pops on return
	always_comb begin
		mem_req = '0;
		if (state_q == SIS_ENTRY && cnt_q < 4'h2) begin
			mem_req.we = 1'b1;
			mem_req.addr = {6'h00, sp_q};
			mem_req.wdata = (cnt_q == 4'h0) ? pc_now[7:0] : pc_now[15:8];
		end else if (state_q == SIS_RETURN && cnt_q < 4'h2) begin
			mem_req.re = 1'b1;
			mem_req.addr = {6'h00, sp_q + 10'h001};
		end
	end

	// popped bytes arrive one cycle after each read, high byte first
	always_ff @(posedge clock) begin
		if (srst) begin
			pc_high_q <= 8'h00;
			pc_low_q <= 8'h00;
		end else if (state_q == SIS_RETURN && cnt_q == 4'h1) begin
			pc_high_q <= mem_rdata;
		end else if (state_q == SIS_RETURN && cnt_q == 4'h2) begin
			pc_low_q <= mem_rdata;
		end
	end

	// new program counter on the last cycle of entry or return
	always_comb begin
		pc_load = entry_last || return_last;
		pc_value = 16'h0000;
		if (entry_last) begin
			pc_value = vec_base + (16'({12'h000, src_q} + 16'h0001) * `SIS_VEC_STRIDE);
		end else if (return_last) begin
			pc_value = {pc_high_q, pc_low_q};
		end
	end

	// stack pointer arithmetic; a software byte write wins over the adjust
	always_comb begin
		sp_d = sp_q;
		if (state_q == SIS_ENTRY && cnt_q < 4'h2) begin
			sp_d = sp_q - 10'h001;
		end else if (state_q == SIS_RETURN && cnt_q < 4'h2) begin
			sp_d = sp_q + 10'h001;
		end else if (state_q == SIS_IDLE) begin
			if (cmd.push_byte) begin
				sp_d = sp_q - 10'h001;
			end else if (cmd.pop_byte) begin
				sp_d = sp_q + 10'h001;
			end else if (cmd.call) begin
				sp_d = sp_q - 10'h002;
			end else if (cmd.ret) begin
				sp_d = sp_q + 10'h002;
			end
		end
		if (wr_spl) begin
			sp_d[7:0] = io_req.wdata;
		end
		if (wr_sph) begin
			sp_d[9:8] = io_req.wdata[`SIS_SP_HIGH_BITS-1:0];
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			sp_q <= `SIS_SP_RESET;
		end else begin
			sp_q <= sp_d;
		end
	end
	assign stack_top_pointer = sp_q;

	// status register: hardware only moves the enable bit, other bits untouched
	always_ff @(posedge clock) begin
		if (srst) begin
			status_q <= `SIS_STATUS_RESET;
		end else begin
			if (wr_status) begin
				status_q <= io_req.wdata;
			end
			if (take || cmd.cli) begin
				status_q[`SIS_GIE_BIT] <= 1'b0;
			end else if (return_last || cmd.sei) begin
				status_q[`SIS_GIE_BIT] <= 1'b1;
			end
		end
	end
	assign global_enable = status_q[`SIS_GIE_BIT];

	// one-instruction hold after set-global or return
	always_ff @(posedge clock) begin
		if (srst) begin
			shadow_q <= 1'b0;
		end else if (return_last || (cmd.sei && cmd.instr_done)) begin
			shadow_q <= 1'b1;
		end else if (cmd.instr_done) begin
			shadow_q <= 1'b0;
		end
	end

	// control and enable registers
	always_ff @(posedge clock) begin
		if (srst) begin
			ctrl_q <= `SIS_CTRL_RESET;
			irq_en_q <= N_SRC'(`SIS_IRQ_RESET);
		end else if (io_req.we) begin
			if (io_req.addr == `SIS_IO_IRQ_CTRL) begin
				ctrl_q <= io_req.wdata;
			end
			if (io_req.addr == `SIS_IO_IRQ_EN) begin
				irq_en_q <= io_req.wdata[N_SRC-1:0];
			end
		end
	end

	// sticky flags; a new event beats both clears in the same cycle
	genvar g;
	for (g = 0; g < N_SRC; g++) begin : g_flag
		logic w1c;
		logic hw_clr;
		assign w1c = io_req.we && io_req.addr == `SIS_IO_IRQ_FLAG && io_req.wdata[g];
		assign hw_clr = take && win_idx == IDX_W'(g);
		always_ff @(posedge clock) begin
			if (srst) begin
				flag_q[g] <= 1'b0;
			end else if (src_event[g] && !LEVEL_MASK[g]) begin
				flag_q[g] <= 1'b1;
			end else if (w1c || hw_clr) begin
				flag_q[g] <= 1'b0;
			end
		end
	end

	// registered read port; unused high stack bits read zero
	always_ff @(posedge clock) begin
		if (srst) begin
			io_rdata <= 8'h00;
		end else if (io_req.re) begin
			unique case (io_req.addr)
				`SIS_IO_SP_LOW: io_rdata <= sp_q[7:0];
				`SIS_IO_SP_HIGH: io_rdata <= {6'h00, sp_q[9:8]};
				`SIS_IO_STATUS: io_rdata <= status_q;
				`SIS_IO_IRQ_CTRL: io_rdata <= ctrl_q;
				`SIS_IO_IRQ_EN: io_rdata <= 8'(irq_en_q);
				`SIS_IO_IRQ_FLAG: io_rdata <= 8'(flag_q);
				default: io_rdata <= 8'h00;
			endcase
		end
	end

	AST_PUSH_ONE: assert property (@(posedge clock) disable iff (srst)
		state_q == SIS_IDLE && cmd.push_byte && !io_req.we |=> sp_q == $past(sp_q) - 10'h001)
		else $error("byte push did not lower stack pointer by one");
	AST_RET_TWO: assert property (@(posedge clock) disable iff (srst)
		state_q == SIS_IDLE && cmd.ret && !cmd.push_byte && !cmd.pop_byte && !cmd.call && !io_req.we
		|=> sp_q == $past(sp_q) + 10'h002)
		else $error("return did not raise stack pointer by two");
	AST_SPH_UNUSED_ZERO: assert property (@(posedge clock) disable iff (srst)
		io_req.re && io_req.addr == `SIS_IO_SP_HIGH |=> io_rdata[7:2] == 6'h00)
		else $error("unused stack pointer high bits read nonzero");
	AST_CLI_BLOCKS: assert property (@(posedge clock) disable iff (srst)
		state_q == SIS_IDLE && cmd.cli && !cmd.return_from_irq |=> state_q == SIS_IDLE)
		else $error("interrupt taken in cycle of clear-global");
	AST_ENTRY_CLEARS_GIE: assert property (@(posedge clock) disable iff (srst)
		state_q == SIS_IDLE ##1 state_q == SIS_ENTRY |-> !status_q[`SIS_GIE_BIT])
		else $error("global enable still set on interrupt entry");
	AST_ENTRY_FOUR: assert property (@(posedge clock) disable iff (srst)
		take && !sleep_ready |=> (!pc_load)[*3] ##1 (pc_load && state_q == SIS_ENTRY))
		else $error("awake interrupt entry not four cycles");
	AST_ENTRY_WAKE: assert property (@(posedge clock) disable iff (srst)
		take && sleep_ready |=> (!pc_load)[*7] ##1 pc_load)
		else $error("wake entry not eight cycles");
	AST_RETURN_FOUR: assert property (@(posedge clock) disable iff (srst)
		ret_go |=> (!pc_load)[*3] ##1 pc_load ##1 (status_q[`SIS_GIE_BIT] && state_q == SIS_IDLE))
		else $error("return not four cycles or enable not set");
	AST_SEI_HOLD: assert property (@(posedge clock) disable iff (srst)
		state_q == SIS_IDLE && cmd.sei && cmd.instr_done |=> state_q != SIS_ENTRY)
		else $error("interrupt taken at the set-global boundary");
	AST_RETURN_HOLD: assert property (@(posedge clock) disable iff (srst)
		state_q == SIS_IDLE && shadow_q && !cmd.instr_done |=> state_q != SIS_ENTRY)
		else $error("interrupt taken before one instruction after return");
	AST_NO_GIE_NO_TAKE: assert property (@(posedge clock) disable iff (srst)
		state_q == SIS_IDLE && !status_q[`SIS_GIE_BIT] |=> state_q != SIS_ENTRY)
		else $error("interrupt taken with global enable clear");
endmodule
`default_nettype wire

// file: sim/sis_stack_mem.sv
// stack memory model that answers the sequencer's stack pushes and pops
`timescale 1ns/1ns
`default_nettype none
module sis_stack_mem import sis_pkg::*; (
	input wire logic clock,
	input wire sis_mem_req_t mem_req,
	output logic [7:0] mem_rdata
);
	logic [7:0] mem [0:1023];
	// read data is valid only the cycle after a read; otherwise inverted so stale bytes never match
	always_ff @(posedge clock) begin
		if (mem_req.we) mem[mem_req.addr[9:0]] <= mem_req.wdata;
		mem_rdata <= mem_req.re ? mem[mem_req.addr[9:0]] : ~mem_rdata;
	end
endmodule
`default_nettype wire

// file: sim/sis_testbench.sv
// self-checking bench for the stack and interrupt sequencer
`timescale 1ns/1ns
`default_nettype none
`include "sis_cfg.svh"
module testbench import sis_pkg::*;;
	int fail_count;
	int cmp_count;
	int n;
	logic clock, srst, pc_load, global_enable, busy, fuse, app_lock, ptr_wb_we;
	sis_cmd_t cmd;
	sis_io_req_t io_req;
	sis_mem_req_t mem_req;
	sis_ptr_mode_t ptr_mode;
	logic [7:0] io_rdata, mem_rdata, src_event, src_level, ptr_low, ptr_high, ptr_wb_low, ptr_wb_high, rd;
	logic [15:0] pc_now, pc_value, reset_vector, ptr_addr;
	logic [9:0] stack_top_pointer;
	logic sleep_ready, wake_req;
	logic [5:0] ptr_disp;
	logic [4:0] ptr_wb_index;

	// source 7 is level type so both request kinds are reachable
	sis_sequencer #(.LEVEL_MASK(8'h80)) dut (.clock(clock), .srst(srst), .cmd(cmd), .io_req(io_req),
		.io_rdata(io_rdata), .pc_now(pc_now), .pc_in_boot(1'b0), .sleep_ready(sleep_ready), .src_event(src_event),
		.src_level(src_level), .boot_reset_fuse(fuse), .app_lock_bit(app_lock), .boot_lock_bit(1'b0),
		.mem_req(mem_req), .mem_rdata(mem_rdata), .pc_load(pc_load), .pc_value(pc_value),
		.reset_vector(reset_vector), .stack_top_pointer(stack_top_pointer), .global_enable(global_enable),
		.busy(busy), .wake_req(wake_req), .ptr_low(ptr_low), .ptr_high(ptr_high), .ptr_sel(2'h0), .ptr_mode(ptr_mode),
		.ptr_disp(ptr_disp), .ptr_addr(ptr_addr), .ptr_wb_index(ptr_wb_index), .ptr_wb_low(ptr_wb_low),
		.ptr_wb_high(ptr_wb_high), .ptr_wb_we(ptr_wb_we));
	sis_stack_mem stk (.clock(clock), .mem_req(mem_req), .mem_rdata(mem_rdata));

	// free-running core clock
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
			fail_count++;
		end
	endtask

	task automatic tick(input int k);
		repeat (k) @(negedge clock);
	endtask

	// every driver leaves a quiet cycle so no signal is assigned twice in one step
	task automatic pulse(input logic [7:0] c);
		cmd = c;
		tick(1);
		cmd = '0;
		tick(1);
	endtask

	task automatic ev(input logic [7:0] e);
		src_event = e;
		tick(1);
		src_event = '0;
		tick(1);
	endtask

	task automatic io_wr(input logic [5:0] a, input logic [7:0] d);
		io_req = {2'b10, a, d};
		tick(1);
		io_req = '0;
		tick(1);
	endtask

	task automatic io_rd(input logic [5:0] a);
		io_req = {2'b01, a, 8'h00};
		tick(1);
		io_req = '0;
		rd = io_rdata;
		tick(1);
	endtask

	// counts sequence cycles up to the load; the calling pulse already spent two of them
	task automatic wait_load();
		n = 2;
		while (pc_load !== 1'b1 && n < 20) begin
			tick(1);
			n++;
		end
	endtask

	task automatic no_load(input int k);
		repeat (k) begin
			tick(1);
			chk("pc_load", 16'h0000, {15'h0, pc_load});
		end
	endtask

	// called in the load cycle, so let the sequence reach idle before the return strobe
	task automatic ret_irq();
		tick(1);
		pulse(8'h09);
		wait_load();
		chk("return load", 16'h0001, {15'h0, pc_load});
		tick(1);
	endtask

	task automatic t_regs();
		io_rd(`SIS_IO_SP_HIGH);
		chk("sp_high reset", 16'h0000, {8'h00, rd});
		io_rd(`SIS_IO_STATUS);
		chk("status reset", 16'h0000, {8'h00, rd});
		io_wr(`SIS_IO_SP_HIGH, 8'hff);
		io_rd(`SIS_IO_SP_HIGH);
		chk("sp_high unused bits", 16'h0003, {8'h00, rd});
		chk("sp low byte kept", 16'h0300, {6'h00, stack_top_pointer});
		// stack placed above the register and I/O area before any call
		io_wr(`SIS_IO_SP_LOW, 8'h5f);
		io_wr(`SIS_IO_SP_HIGH, 8'h02);
		io_rd(`SIS_IO_SP_LOW);
		chk("sp_low read", 16'h005f, {8'h00, rd});
		$display("test regs done");
	endtask

	task automatic t_stack();
		logic [7:0] c [4] = '{8'h80, 8'h40, 8'h20, 8'h10};
		logic [15:0] e [4] = '{16'h025e, 16'h025f, 16'h025d, 16'h025f};
		for (int i = 0; i < 4; i++) begin
			pulse(c[i]);
			chk("sp step", e[i], {6'h00, stack_top_pointer});
		end
		$display("test stack done");
	endtask

	task automatic t_irq();
		io_wr(`SIS_IO_IRQ_EN, 8'h02);
		ev(8'h02);
		pc_now = 16'h1234;
		pulse(8'h05);
		chk("gie set", 16'h0001, {15'h0, global_enable});
		chk("sei boundary", 16'h0000, {15'h0, busy});
		pulse(8'h01);
		wait_load();
		chk("entry cycles", 16'h0004, n[15:0]);
		chk("vector", 16'h0004, pc_value);
		chk("gie cleared", 16'h0000, {15'h0, global_enable});
		chk("sp entry", 16'h025d, {6'h00, stack_top_pointer});
		chk("pushed low", 16'h0034, {8'h00, stk.mem[10'h25f]});
		chk("pushed high", 16'h0012, {8'h00, stk.mem[10'h25e]});
		io_rd(`SIS_IO_IRQ_FLAG);
		chk("flag cleared", 16'h0000, {8'h00, rd});
		// handler changes the low status bits; hardware must not undo that
		io_wr(`SIS_IO_STATUS, 8'h03);
		ev(8'h02);
		pulse(8'h09);
		wait_load();
		chk("return cycles", 16'h0004, n[15:0]);
		chk("popped pc", 16'h1234, pc_value);
		tick(1);
		chk("gie return", 16'h0001, {15'h0, global_enable});
		chk("sp return", 16'h025f, {6'h00, stack_top_pointer});
		io_rd(`SIS_IO_STATUS);
		chk("status kept", 16'h0083, {8'h00, rd});
		no_load(4);
		pulse(8'h01);
		wait_load();
		chk("pending served", 16'h0004, pc_value);
		ret_irq();
		$display("test irq done");
	endtask

	task automatic t_cli();
		io_wr(`SIS_IO_IRQ_EN, 8'h03);
		ev(8'h01);
		pulse(8'h03);
		no_load(6);
		chk("gie off", 16'h0000, {15'h0, global_enable});
		ev(8'h02);
		pulse(8'h05);
		pulse(8'h01);
		wait_load();
		chk("first by priority", 16'h0002, pc_value);
		ret_irq();
		pulse(8'h01);
		wait_load();
		chk("second latched", 16'h0004, pc_value);
		ret_irq();
		$display("test cli done");
	endtask

	task automatic t_vsel();
		chk("reset vector", 16'h0000, reset_vector);
		fuse = 1'b1;
		tick(1);
		chk("reset vector boot", 16'h0c00, reset_vector);
		io_wr(`SIS_IO_IRQ_CTRL, 8'h02);
		app_lock = 1'b1;
		ev(8'h02);
		pulse(8'h01);
		no_load(6);
		app_lock = 1'b0;
		pulse(8'h01);
		wait_load();
		chk("moved vector", 16'h0c04, pc_value);
		ret_irq();
		io_wr(`SIS_IO_IRQ_CTRL, 8'h00);
		$display("test vsel done");
	endtask

	task automatic t_mask();
		io_wr(`SIS_IO_IRQ_EN, 8'h80);
		ev(8'h04);
		pulse(8'h03);
		src_level = 8'h80;
		tick(2);
		// condition vanishes before the global enable returns
		src_level = 8'h00;
		pulse(8'h05);
		pulse(8'h01);
		no_load(6);
		src_level = 8'h80;
		pulse(8'h01);
		wait_load();
		chk("level vector", 16'h0010, pc_value);
		src_level = 8'h00;
		ret_irq();
		$display("test mask done");
	endtask

	// enable set by a status write so no hold is pending; the wake takes the longer entry
	task automatic t_wake();
		io_wr(`SIS_IO_IRQ_EN, 8'h02);
		pulse(8'h03);
		io_wr(`SIS_IO_STATUS, 8'h80);
		ev(8'h02);
		sleep_ready = 1'b1;
		#1;
		chk("wake_req", 16'h0001, {15'h0, wake_req});
		tick(1);
		sleep_ready = 1'b0;
		tick(1);
		wait_load();
		chk("wake entry cycles", 16'h0008, n[15:0]);
		chk("wake vector", 16'h0004, pc_value);
		ret_irq();
		$display("test wake done");
	endtask

	task automatic t_ptr();
		ptr_low = 8'hff;
		ptr_high = 8'h01;
		ptr_mode = SIS_PTR_POSTINC;
		tick(1);
		chk("postinc addr", 16'h01ff, ptr_addr);
		chk("postinc wb", 16'h0200, {ptr_wb_high, ptr_wb_low});
		ptr_mode = SIS_PTR_PREDEC;
		tick(1);
		chk("predec addr", 16'h01fe, ptr_addr);
		chk("predec wb", 16'h01fe, {ptr_wb_high, ptr_wb_low});
		ptr_mode = SIS_PTR_DISP;
		ptr_disp = 6'h3f;
		tick(1);
		chk("disp addr", 16'h023e, ptr_addr);
		chk("disp no wb", 16'h0000, {15'h0, ptr_wb_we});
		chk("wb index", 16'h001a, {11'h0, ptr_wb_index});
		$display("test ptr done");
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// main sequence: reset, then the scenarios in order
	initial begin
		fail_count = 0;
		cmp_count = 0;
		srst = 1'b1;
		cmd = '0;
		io_req = '0;
		pc_now = 16'h0000;
		src_event = 8'h00;
		src_level = 8'h00;
		fuse = 1'b0;
		app_lock = 1'b0;
		ptr_low = 8'h00;
		ptr_high = 8'h00;
		ptr_mode = SIS_PTR_PLAIN;
		sleep_ready = 1'b0;
		ptr_disp = 6'h00;
		tick(6);
		srst = 1'b0;
		t_regs();
		t_stack();
		t_irq();
		t_cli();
		t_vsel();
		t_mask();
		t_wake();
		t_ptr();
		complete_run();
	end

	// watchdog: the scenarios need under two hundred cycles
	initial begin
		repeat (3000) @(posedge clock);
		$display("watchdog expired");
		fail_count++;
		complete_run();
	end
endmodule
`default_nettype wire
